// file: tb/bridge_port_properties.sv
// concurrent checks of the bridge serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module bridge_port_checker
  import bridge_pkg::*;
#(
  parameter int WDOG_CYCLES    = 8125000,
  parameter int STANDBY_CYCLES = 6250,
  parameter int CNT_W          = 23
) (
  input wire logic         clock_in,
  input wire logic         nrst_in,
  input wire logic         sclk_in,
  input wire logic         cs_in,
  input wire logic         overtemp_a_in,
  input wire logic         overtemp_b_in,
  input wire logic         supply_low_in,
  input wire logic         open_load_in,
  input wire logic         sdo_out,
  input wire logic         sdo_oe_out,
  input wire bridge_mode_t drive_mode_out,
  input wire logic         slope_fast_out,
  input wire logic         sense_on_out,
  input wire logic         watchdog_on_out,
  input wire logic         outputs_off_out,
  input wire logic         standby_out
);
  // slack covers the crossing of the off state into the standby counter
  localparam int STB_LIM = STANDBY_CYCLES + 8;

  // cycles spent off and not yet in standby; counted, the limit may be long
  logic [CNT_W-1:0] off_cnt_r;

  // any unlatched fault level at the pins
  wire logic lvl_any = overtemp_a_in | overtemp_b_in | supply_low_in | open_load_in;

  // off-time counter, cleared outside the off state
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || !outputs_off_out || standby_out)
      off_cnt_r <= '0;
    else
      off_cnt_r <= off_cnt_r + CNT_W'(1);
  end

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  // select edges as seen through the system clock
  sequence cs_up;
    $rose(cs_in);
  endsequence
  sequence cs_down;
    $fell(cs_in);
  endsequence

  oe_on_select_a: assert property (cs_up |-> ##[2:4] sdo_oe_out)
    else $error("serial output not enabled after select rise");
  oe_idle_a: assert property (!cs_in [*5] |-> !sdo_oe_out)
    else $error("serial output driven without select");
  oe_release_a: assert property (cs_down |-> ##[2:4] !sdo_oe_out)
    else $error("serial output not released after select fall");
  flag_fault_a: assert property ($rose(sdo_oe_out) && $past(lvl_any, 3) && $past(lvl_any, 5)
    |-> sdo_out)
    else $error("fault flag low while a fault is present");
  reset_values_a: assert property ($rose(nrst_in) |-> !watchdog_on_out && !slope_fast_out
    && !sense_on_out && outputs_off_out && !sdo_oe_out)
    else $error("wrong output values out of reset");
  cfg_hold_a: assert property (cs_in && $past(cs_in, 5) |-> $stable(slope_fast_out)
    && $stable(sense_on_out) && $stable(watchdog_on_out))
    else $error("control changed inside a frame");
  sdo_after_rise_a: assert property (cs_in && sdo_oe_out && $past(sdo_oe_out) && $changed(sdo_out)
    |-> $past(sclk_in, 3) || $past(sclk_in, 4) || $past(sclk_in, 5))
    else $error("serial output moved without a clock rise");
  standby_entry_a: assert property (off_cnt_r <= CNT_W'(STB_LIM))
    else $error("standby not entered in time");
  off_until_select_a: assert property (outputs_off_out && !cs_in && $past(nrst_in)
    |=> outputs_off_out)
    else $error("outputs left off state without select rise");
  drive_off_a: assert property (outputs_off_out && $past(outputs_off_out)
    |-> drive_mode_out == 4'h0)
    else $error("bridge driven while outputs are off");
endmodule

bind bridge_driver_spi_ctrl_status bridge_port_checker #(
  .WDOG_CYCLES(WDOG_CYCLES), .STANDBY_CYCLES(STANDBY_CYCLES), .CNT_W(CNT_W)
) port_chk (
  .clock_in, .nrst_in, .sclk_in, .cs_in, .overtemp_a_in, .overtemp_b_in, .supply_low_in,
  .open_load_in, .sdo_out, .sdo_oe_out, .drive_mode_out, .slope_fast_out, .sense_on_out,
  .watchdog_on_out, .outputs_off_out, .standby_out
);

`default_nettype wire

// file: tb/spi_master_model.sv
// serial master model that runs select frames on the bridge port
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  output logic      sclk_out,
  output logic      cs_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  // released output line is held high by the chain pull-up
  wire logic line = sdo_oe_in ? sdo_in : 1'b1;

  // clock stands low outside frames
  initial
  begin
    sclk_out = 1'b0;
    cs_out   = 1'b0;
    sdi_out  = 1'b0;
  end

  // one select cycle of n clocks; 125 ns clock period, edges kept off the system grid
  task automatic xfer(input int n, input logic [15:0] tx, output logic flag,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    #4000;
    cs_out = 1'b1;
    #301.25;
    flag = line;
    for (i = n - 1; i >= 0; i--)
    begin
      sdi_out  = tx[i];
      sclk_out = 1'b1;
      #62.5;
      rx       = {rx[14:0], line};
      sclk_out = 1'b0;
      #62.5;
    end
    #125;
    cs_out = 1'b0;
    #125;
    // released input must not look like held data
    sdi_out = ~sdi_out;
  endtask
endmodule

`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench of the bridge serial port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import bridge_pkg::*;
  // short watchdog and standby counts keep the run brief
  localparam int WDOG = 3000;
  localparam int STB  = 20;

  logic         clock_in = 1'b0;
  logic         nrst_in  = 1'b0;
  logic         ot_a = 1'b0, ot_b = 1'b0, low = 1'b0, open_l = 1'b0, oc_a = 1'b0, oc_b = 1'b0;
  wire logic    sclk, cs, sdi, sdo, sdo_oe, slope, sense, sense_a, wdog, off, stby;
  bridge_mode_t mode;
  int           error_cnt = 0;
  int           checks = 0;
  logic         flag;
  logic [15:0]  rx;

  always #4 clock_in = ~clock_in;

  spi_master_model master (.sclk_out(sclk), .cs_out(cs), .sdi_out(sdi), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe));

  bridge_driver_spi_ctrl_status #(.WDOG_CYCLES(WDOG), .STANDBY_CYCLES(STB), .CNT_W(23)) DUT (
    .clock_in, .nrst_in, .ce_in(1'b1), .sclk_in(sclk), .cs_in(cs), .sdi_in(sdi),
    .overtemp_a_in(ot_a), .overtemp_b_in(ot_b), .supply_low_in(low), .open_load_in(open_l),
    .overcurrent_a_in(oc_a), .overcurrent_b_in(oc_b), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .drive_mode_out(mode), .slope_fast_out(slope), .sense_on_out(sense),
    .sense_bridge_a_out(sense_a), .watchdog_on_out(wdog), .outputs_off_out(off),
    .standby_out(stby));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a frame, then time for the word to cross and reach the outputs
  task automatic frame(input int n, input logic [15:0] tx);
    master.xfer(n, tx, flag, rx);
    repeat (12) @(negedge clock_in);
  endtask

  task automatic t_rw();
    chk({slope, sense, sense_a, wdog, mode}, 16'h0000, "reset outputs");
    frame(8, 16'h0074);
    chk(rx[7:0], 8'h00, "reset readback");
    chk(flag, 1'b0, "idle flag");
    chk({slope, sense, sense_a}, 3'b111, "slope sense choice");
    chk(mode, 4'h3, "mode bits");
    frame(16, 16'ha512);
    chk(rx[15:8], 8'h74, "control readback");
    chk(rx[7:0], 8'ha5, "chained bits");
    chk({slope, sense, sense_a, mode}, 7'h15, "last byte applied");
  endtask

  task automatic t_status();
    @(negedge clock_in);
    ot_a = 1'b1;
    low  = 1'b1;
    frame(8, 16'h0001);
    frame(8, 16'h0001);
    chk(flag, 1'b1, "flag with faults");
    chk(rx[7:0], 8'h31, "status byte");
    @(negedge clock_in);
    {ot_a, low, ot_b, open_l} = 4'h3;
    frame(8, 16'h0001);
    frame(8, 16'h0001);
    chk(rx[7:0], 8'h49, "status after change");
    @(negedge clock_in);
    {ot_b, open_l} = 2'b00;
    frame(8, 16'h0001);
    frame(8, 16'h0001);
    chk({flag, rx[7:0]}, 9'h001, "clear status");
  endtask

  task automatic t_overcurrent();
    @(negedge clock_in);
    oc_b = 1'b1;
    repeat (4) @(negedge clock_in);
    oc_b = 1'b0;
    frame(8, 16'h0001);
    chk({flag, rx[7:0]}, 9'h105, "latched overcurrent");
    frame(8, 16'h0005);
    chk(rx[7:0], 8'h05, "status held for frame");
    chk(mode.bridge_b_input, 1'b0, "recovery hold");
    repeat (900) @(negedge clock_in);
    chk(mode.bridge_b_input, 1'b1, "recovered switch");
    frame(8, 16'h0001);
    frame(8, 16'h0001);
    chk(rx[7:0], 8'h01, "overcurrent cleared");
  endtask

  task automatic t_bad_count();
    frame(8, 16'h0040);
    chk(slope, 1'b1, "fast slope");
    frame(5, 16'h0015);
    chk({off, slope}, 2'b10, "failure on bad count");
    repeat (STB + 10) @(negedge clock_in);
    chk(stby, 1'b1, "standby entered");
    frame(0, 16'h0000);
    chk({off, slope, mode}, 6'h00, "resume on select");
  endtask

  task automatic t_watchdog();
    frame(8, 16'h0080);
    chk(wdog, 1'b1, "watchdog on");
    repeat (WDOG / 2) @(negedge clock_in);
    frame(8, 16'h0080);
    chk(off, 1'b0, "serviced watchdog");
    repeat (WDOG + 50) @(negedge clock_in);
    chk({off, wdog}, 2'b10, "watchdog expiry");
    frame(8, 16'h0000);
    chk(off, 1'b0, "resume after expiry");
  endtask

  initial
  begin
    repeat (16) @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clock_in);
    t_rw();
    t_status();
    t_overcurrent();
    t_bad_count();
    t_watchdog();
    close_out();
  end

  // hang guard: about eighteen frames and the waits take near 150 us
  initial
  begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule

`default_nettype wire

// file: verilog/bit_sync.sv
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else if (ce_in)
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: verilog/bridge_defs_defs.svh
// field positions, reset values and timing figures of the bridge serial port
`ifndef BRIDGE_DEFS_DEFS_SVH
`define BRIDGE_DEFS_DEFS_SVH

// frame length in serial clocks
`define FRAME_BITS      8

// drive_config_byte field positions, shifted msb first
`define CFG_WDOG_POS    7
`define CFG_SLOPE_POS   6
`define CFG_SENSE_POS   5
`define CFG_CHOICE_POS  4
`define CFG_MOD_POS     3
`define CFG_B_IN_POS    2
`define CFG_A_IN_POS    1
`define CFG_READ_POS    0
`define CFG_RESET       8'h00

// device_fault_byte field positions
`define STS_WDOG_POS    7
`define STS_OT_B_POS    6
`define STS_OT_A_POS    5
`define STS_LOW_POS     4
`define STS_OPEN_POS    3
`define STS_OC_B_POS    2
`define STS_OC_A_POS    1
`define STS_READ_POS    0
`define STS_RESET       8'h00

// timing figures in their own units, system clock in mhz
`define CLK_MHZ         125
`define T_WDOG_MS       65
`define T_STANDBY_US    50
`define T_REC_MIN_US    7
`define T_REC_MAX_US    25

`endif

// file: verilog/bridge_driver_spi_ctrl_status.sv
// serial control and diagnostic port of a full-bridge motor driver
//
// What this block does
// - chip select is active high; frame bits are accepted only while high
// - on select falling, decode the received word and apply it as control
// - on select falling, release the serial output to high impedance
// - sample the serial input on every falling serial clock edge
// - update the serial output after every rising serial clock edge
// - transfers are whole eight-bit frames, one byte per device
// - readback choice 0 returns control byte, 1 returns status byte
// - drive global fault flag from select rising until first rising clock
// - global fault flag is the OR of all six fault flags
// - watchdog_on resets to 0; writing 1 enables supervision
// - slope_speed 1 selects fast slew, 0 slow; resets to 0
// - sense_on 1 enables current sense output; resets to 0
// - bridge_choice 1 senses half-bridge A, 0 half-bridge B; resets to 0
// - modulation, both inputs and bridge_choice together pick the mode
// - readback_choice resets to 0 so control byte is returned first
// - status byte holds per-bridge overtemp and overcurrent, low supply, open load
// - status byte also reports watchdog_on and readback_choice
// - after watchdog failure enter standby within at most 50 us
// - after commanded recovery resume switching within 7 to 25 us
// - input bits pass the eight-bit shifter to the output for chaining
// - missed select fall or bad clock count is a watchdog failure
// - after failure stay off until select rises, then follow new control
// - latched overcurrent clears only when control commands that switch on, or on a failure
// - supply low flag follows the supply and is not latched
`timescale 1ns/1ps
`default_nettype none
`include "bridge_defs_defs.svh"

module bridge_driver_spi_ctrl_status
  import bridge_pkg::*;
#(
  parameter int WDOG_CYCLES    = `T_WDOG_MS * 1000 * `CLK_MHZ,
  parameter int STANDBY_CYCLES = `T_STANDBY_US * `CLK_MHZ,
  parameter int CNT_W          = 23
) (
  input  wire logic   clock_in,
  input  wire logic   nrst_in,
  input  wire logic   ce_in,
  input  wire logic   sclk_in,
  input  wire logic   cs_in,
  input  wire logic   sdi_in,
  input  wire logic   overtemp_a_in,
  input  wire logic   overtemp_b_in,
  input  wire logic   supply_low_in,
  input  wire logic   open_load_in,
  input  wire logic   overcurrent_a_in,
  input  wire logic   overcurrent_b_in,
  output logic        sdo_out,
  output logic        sdo_oe_out,
  output var bridge_mode_t drive_mode_out,
  output logic        slope_fast_out,
  output logic        sense_on_out,
  output logic        sense_bridge_a_out,
  output logic        watchdog_on_out,
  output logic        outputs_off_out,
  output logic        standby_out
);

  // recovery delay: least time rounds up to whole cycles
  localparam int REC_CYCLES = `T_REC_MIN_US * `CLK_MHZ;
  localparam int BITS       = `FRAME_BITS;

  // field decode from a received byte, used at reset and on each frame
  function automatic drive_config_t unpack_cfg(input logic [7:0] b);
    drive_config_t c;
    c.watchdog_on     = b[`CFG_WDOG_POS];
    c.slope_speed     = b[`CFG_SLOPE_POS];
    c.sense_on        = b[`CFG_SENSE_POS];
    c.bridge_choice   = b[`CFG_CHOICE_POS];
    c.modulation      = b[`CFG_MOD_POS];
    c.bridge_b_input  = b[`CFG_B_IN_POS];
    c.bridge_a_input  = b[`CFG_A_IN_POS];
    c.readback_choice = b[`CFG_READ_POS];
    return c;
  endfunction

  // control byte as shifted back out
  function automatic logic [7:0] pack_cfg(input drive_config_t c);
    logic [7:0] b;
    b = 8'h00;
    b[`CFG_WDOG_POS]   = c.watchdog_on;
    b[`CFG_SLOPE_POS]  = c.slope_speed;
    b[`CFG_SENSE_POS]  = c.sense_on;
    b[`CFG_CHOICE_POS] = c.bridge_choice;
    b[`CFG_MOD_POS]    = c.modulation;
    b[`CFG_B_IN_POS]   = c.bridge_b_input;
    b[`CFG_A_IN_POS]   = c.bridge_a_input;
    b[`CFG_READ_POS]   = c.readback_choice;
    return b;
  endfunction

  logic [6:0]      pin_s;
  logic            cs_s;
  logic            cs_d_r;
  logic            cs_rise;
  logic            cs_fall;
  fault_flags_t    live_f;
  logic            oc_a_r;
  logic            oc_b_r;
  fault_flags_t    flags;
  logic            fault_any;
  drive_config_t   cfg_r;
  drive_config_t   rx_cfg;
  logic [7:0]      status_byte;
  logic [7:0]      readback_r;
  logic            link_tx;
  logic            link_clocked;
  logic [2:0]      link_cnt;
  logic [BITS-1:0] link_rx;
  logic [1:0]      out_s;
  logic [10:0]     word_s;
  logic [BITS-1:0] shadow_rx_r;
  logic [2:0]      shadow_cnt_r;
  logic            shadow_clk_r;
  logic            frame_good;
  logic            frame_bad;
  logic [CNT_W-1:0] wdog_cnt_r;
  logic            wdog_expired;
  logic            fail;
  supervise_t      state_r;
  supervise_t      state_nxt;
  logic [CNT_W-1:0] stby_cnt_r;
  logic [9:0]      rec_cnt_r;
  logic            rec_a_r;
  logic            rec_b_r;
  logic            allow_a;
  logic            allow_b;

  // pins from outside both domains pass two flops first
  bit_sync #(
    .WIDTH (7)
  ) u_pin_sync (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .async_in ({cs_in, overtemp_a_in, overtemp_b_in, supply_low_in,
                open_load_in, overcurrent_a_in, overcurrent_b_in}),
    .sync_out (pin_s)
  );

  // link side runs on the master's clock
  spi_link_shifter #(
    .BITS (BITS)
  ) u_link (
    .sclk_in     (sclk_in),
    .cs_in       (cs_in),
    .sdi_in      (sdi_in),
    .readback_in (readback_r),
    .tx_bit_out  (link_tx),
    .clocked_out (link_clocked),
    .bit_cnt_out (link_cnt),
    .rx_out      (link_rx)
  );

  // output bit and first-edge marker cross back together
  bit_sync #(
    .WIDTH (2)
  ) u_out_sync (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .async_in ({link_clocked, link_tx}),
    .sync_out (out_s)
  );

  // received word and count are static once the serial clock has stopped
  bit_sync #(
    .WIDTH (11)
  ) u_word_sync (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .async_in ({link_cnt, link_rx}),
    .sync_out (word_s)
  );

  assign cs_s    = pin_s[6];
  assign cs_rise = cs_s && !cs_d_r;
  assign cs_fall = !cs_s && cs_d_r;

  // undervoltage, overtemp and open load follow their inputs unlatched
  assign live_f.overtemp_a_flag    = pin_s[5];
  assign live_f.overtemp_b_flag    = pin_s[4];
  assign live_f.supply_low_flag    = pin_s[3];
  assign live_f.open_load_flag     = pin_s[2];
  assign live_f.overcurrent_a_flag = pin_s[1];
  assign live_f.overcurrent_b_flag = pin_s[0];

  // latched overcurrent replaces the raw pulse in the flag set
  always_comb
  begin
    flags                    = live_f;
    flags.overcurrent_a_flag = oc_a_r;
    flags.overcurrent_b_flag = oc_b_r;
  end

  assign fault_any = |flags;

  // status byte assembly
  always_comb
  begin
    status_byte                = `STS_RESET;
    status_byte[`STS_WDOG_POS] = cfg_r.watchdog_on;
    status_byte[`STS_OT_B_POS] = flags.overtemp_b_flag;
    status_byte[`STS_OT_A_POS] = flags.overtemp_a_flag;
    status_byte[`STS_LOW_POS]  = flags.supply_low_flag;
    status_byte[`STS_OPEN_POS] = flags.open_load_flag;
    status_byte[`STS_OC_B_POS] = flags.overcurrent_b_flag;
    status_byte[`STS_OC_A_POS] = flags.overcurrent_a_flag;
    status_byte[`STS_READ_POS] = cfg_r.readback_choice;
  end

  assign rx_cfg       = unpack_cfg(shadow_rx_r);
  assign frame_good   = cs_fall && shadow_clk_r && (shadow_cnt_r == 3'h0);
  assign frame_bad    = cs_fall && shadow_clk_r && (shadow_cnt_r != 3'h0);
  assign wdog_expired = cfg_r.watchdog_on && (state_r == st_run)
                        && (wdog_cnt_r == CNT_W'(WDOG_CYCLES - 1));
  assign fail         = (state_r == st_run) && (frame_bad || wdog_expired);

  // select edge detection
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      cs_d_r <= 1'b0;
    else if (ce_in)
      cs_d_r <= cs_s;
  end

  // keep a copy of the link word while select is high, the link clears on fall
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      shadow_rx_r  <= '0;
      shadow_cnt_r <= 3'h0;
      shadow_clk_r <= 1'b0;
    end
    else if (ce_in && cs_s)
    begin
      shadow_rx_r  <= word_s[BITS-1:0];
      shadow_cnt_r <= word_s[10:8];
      shadow_clk_r <= out_s[1];
    end
  end

  // drive_config_byte: defaults at reset and on failure, new word on good frame
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      cfg_r <= unpack_cfg(`CFG_RESET);
    else if (ce_in)
    begin
      if (fail)
        cfg_r <= unpack_cfg(`CFG_RESET);
      else if (frame_good)
        cfg_r <= rx_cfg;
    end
  end

  // overcurrent latches; a new event wins over a clearing command
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      oc_a_r <= 1'b0;
      oc_b_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (live_f.overcurrent_a_flag)
        oc_a_r <= 1'b1;
      else if (fail || (frame_good && rx_cfg.bridge_a_input))
        oc_a_r <= 1'b0;
      if (live_f.overcurrent_b_flag)
        oc_b_r <= 1'b1;
      else if (fail || (frame_good && rx_cfg.bridge_b_input))
        oc_b_r <= 1'b0;
    end
  end

  // recovery hold-off after a latched fault is cleared by command
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      rec_a_r   <= 1'b0;
      rec_b_r   <= 1'b0;
      rec_cnt_r <= 10'h000;
    end
    else if (ce_in)
    begin
      if (frame_good && ((oc_a_r && rx_cfg.bridge_a_input)
                         || (oc_b_r && rx_cfg.bridge_b_input)))
      begin
        rec_a_r   <= rec_a_r || (oc_a_r && rx_cfg.bridge_a_input);
        rec_b_r   <= rec_b_r || (oc_b_r && rx_cfg.bridge_b_input);
        rec_cnt_r <= 10'h000;
      end
      else if (rec_a_r || rec_b_r)
      begin
        if (rec_cnt_r == 10'(REC_CYCLES - 1))
        begin
          rec_a_r <= 1'b0;
          rec_b_r <= 1'b0;
        end
        else
          rec_cnt_r <= rec_cnt_r + 10'h001;
      end
    end
  end

  // readback byte captured at select rising and held for the frame
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      readback_r <= `CFG_RESET;
    else if (ce_in && cs_rise)
      readback_r <= cfg_r.readback_choice ? status_byte : pack_cfg(cfg_r);
  end

  // serial output: fault flag until first rising clock, then link data
  // the crossing adds about three system cycles, well inside half a clock
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      sdo_oe_out <= cs_s;
      if (!cs_s)
        sdo_out <= 1'b0;
      else if (!out_s[1])
        sdo_out <= fault_any;
      else
        sdo_out <= out_s[0];
    end
  end

  // watchdog timer, restarted by every select falling edge
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      wdog_cnt_r <= '0;
    else if (ce_in)
    begin
      if (cs_fall || !cfg_r.watchdog_on || state_r != st_run)
        wdog_cnt_r <= '0;
      else if (!wdog_expired)
        wdog_cnt_r <= wdog_cnt_r + CNT_W'(1);
    end
  end

  // supervision: run, off after failure, standby after blanking time
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      st_run:
        if (fail)
          state_nxt = st_off;
      st_off:
        if (cs_rise)
          state_nxt = st_run;
        else if (stby_cnt_r == CNT_W'(STANDBY_CYCLES - 1))
          state_nxt = st_standby;
      st_standby:
        if (cs_rise)
          state_nxt = st_run;
      default:
        state_nxt = st_off;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      state_r <= st_run;
    else if (ce_in)
      state_r <= state_nxt;
  end

  // standby blanking counter
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      stby_cnt_r <= '0;
    else if (ce_in)
    begin
      if (state_r != st_off)
        stby_cnt_r <= '0;
      else
        stby_cnt_r <= stby_cnt_r + CNT_W'(1);
    end
  end

  // a half-bridge drives only without its own overtemp or overcurrent, low supply or recovery wait
  assign allow_a = !flags.overtemp_a_flag && !oc_a_r && !rec_a_r
                   && !flags.supply_low_flag;
  assign allow_b = !flags.overtemp_b_flag && !oc_b_r && !rec_b_r
                   && !flags.supply_low_flag;

  // outputs to the power stage, modulation, bridge inputs and sense off outside normal operation
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      drive_mode_out     <= '0;
      slope_fast_out     <= 1'b0;
      sense_on_out       <= 1'b0;
      sense_bridge_a_out <= 1'b0;
      watchdog_on_out    <= 1'b0;
      outputs_off_out    <= 1'b1;
      standby_out        <= 1'b0;
    end
    else if (ce_in)
    begin
      drive_mode_out.modulation     <= cfg_r.modulation && state_r == st_run;
      drive_mode_out.bridge_a_input <= cfg_r.bridge_a_input && allow_a
                                       && state_r == st_run;
      drive_mode_out.bridge_b_input <= cfg_r.bridge_b_input && allow_b
                                       && state_r == st_run;
      drive_mode_out.bridge_choice  <= cfg_r.bridge_choice;
      slope_fast_out     <= cfg_r.slope_speed;
      sense_on_out       <= cfg_r.sense_on && !flags.supply_low_flag
                            && state_r == st_run;
      sense_bridge_a_out <= cfg_r.bridge_choice;
      watchdog_on_out    <= cfg_r.watchdog_on;
      outputs_off_out    <= state_r != st_run;
      standby_out        <= state_r == st_standby;
    end
  end

endmodule
`default_nettype wire

// file: verilog/bridge_pkg.sv
// shared types of the bridge serial port
package bridge_pkg;

  typedef struct packed {
    logic watchdog_on;
    logic slope_speed;
    logic sense_on;
    logic bridge_choice;
    logic modulation;
    logic bridge_b_input;
    logic bridge_a_input;
    logic readback_choice;
  } drive_config_t;

  typedef struct packed {
    logic overtemp_a_flag;
    logic overtemp_b_flag;
    logic supply_low_flag;
    logic open_load_flag;
    logic overcurrent_a_flag;
    logic overcurrent_b_flag;
  } fault_flags_t;

  typedef struct packed {
    logic modulation;
    logic bridge_a_input;
    logic bridge_b_input;
    logic bridge_choice;
  } bridge_mode_t;

  typedef enum logic [2:0] {
    st_run     = 3'b001,
    st_off     = 3'b010,
    st_standby = 3'b100
  } supervise_t;

endpackage

// file: verilog/spi_link_shifter.sv
// serial-clock side of the bridge port: receive shifter and output path
`timescale 1ns/1ps
`default_nettype none

module spi_link_shifter #(
  parameter int BITS = 8
) (
  input  wire logic            sclk_in,
  input  wire logic            cs_in,
  input  wire logic            sdi_in,
  input  wire logic [BITS-1:0] readback_in,
  output logic                 tx_bit_out,
  output logic                 clocked_out,
  output logic      [2:0]      bit_cnt_out,
  output logic      [BITS-1:0] rx_out
);

  logic [BITS-2:0] pass_r;

  // rising edges: first one loads the held byte, later ones pass data on
  // the link clock stops outside frames, so a low select clears the state
  always_ff @(posedge sclk_in or negedge cs_in)
  begin
    if (!cs_in)
    begin
      clocked_out <= 1'b0;
      tx_bit_out  <= 1'b0;
      pass_r      <= '0;
    end
    else if (!clocked_out)
    begin
      clocked_out <= 1'b1;
      tx_bit_out  <= readback_in[BITS-1];
      pass_r      <= readback_in[BITS-2:0];
    end
    else
    begin
      tx_bit_out <= pass_r[BITS-2];
      pass_r     <= {pass_r[BITS-3:0], rx_out[0]};
    end
  end

  // falling edges sample the input line and count clocks
  always_ff @(negedge sclk_in or negedge cs_in)
  begin
    if (!cs_in)
    begin
      rx_out      <= '0;
      bit_cnt_out <= 3'h0;
    end
    else
    begin
      rx_out      <= {rx_out[BITS-2:0], sdi_in};
      bit_cnt_out <= bit_cnt_out + 3'h1;
    end
  end

endmodule
`default_nettype wire
